// ### lsw_top.v
// Serial control port, mode control and pin logic of a quad lamp switch
//
// Behaviour
// - Any direct input, wake input or reset pin high wakes the device.
// - With direct control, each direct input drives its power output.
// - In PWM mode the PWM clock is taken from direct input zero.
// - Open-drain fault flag pulls low on any fault; causes only in frames.
// - Reset pin low clears configuration and fail-safe and allows sleep.
// - Reset pin rising starts the watchdog timer.
// - Serial output driven only with chip select low; floating from reset.
// - Chip select rising queues a complete frame; the addressed register is written as it is drained.
// - Chip select falling loads the status snapshot into the shift register.
// - Input sampled on falling clock edges; output changes on rising edges.
// - With chip select high, clock and data are ignored, output floats.
// - Frames are exactly sixteen bits both ways, MSB first.
// - A five-bit address field selects the target register.
// - Output frame reports output status, configuration and key inputs.
// - Logic supply loss and serial link failure lead to fail-safe.
// - Open enable pin arms the watchdog; on timeout outputs follow inputs.
// - Supply failure with its enable bit set makes outputs follow inputs.
// - Configuration selects sense source and can float the sense output.
// - Normal mode serial control; fail-safe follows inputs with defaults.
// - No wake source means sleep with every power output off.
// - Host toggles the top frame bit within the watchdog timeout.
// - In sleep every serial setting reads as zero.
`include "lsw_defs.vh"

module lsw_top #(
  parameter WD_TIMEOUT_CYC = (`LSW_WD_TIMEOUT_US * 1000) / `LSW_CLK_PERIOD_NS,
  parameter WD_W = 24,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Serial link
  input wire i_sclk,
  input wire i_serial_in,
  input wire i_chip_select_n,
  output wire o_serial_out,
  output reg o_serial_out_oe_n,
  // Control pins
  input wire i_reset_n_pin,
  input wire i_wake,
  input wire [3:0] i_direct_inputs,
  input wire i_watchdog_enable_pin,
  // Analog side status
  input wire i_vdd_fail,
  input wire [3:0] i_fault_detect,
  input wire [3:0] i_pwm_duty,
  // Power and fault pins
  output reg [3:0] o_power_outputs,
  output reg o_pwm_clk,
  output reg o_fault_flag_n_out,
  output reg o_fault_flag_n_oe_n,
  // Sense output control
  output reg [2:0] o_sense_select,
  output reg o_sense_hiz,
  // Mode and frame monitor
  output reg [1:0] o_mode,
  output reg o_frame_overrun,
  output wire o_frame_valid,
  output wire [15:0] o_frame_data,
  input wire i_frame_ready
);

  localparam [1:0] MODE_SLEEP = 2'h0;
  localparam [1:0] MODE_NORMAL = 2'h1;
  localparam [1:0] MODE_FAILSAFE = 2'h2;
  localparam [WD_W-1:0] WD_LAST = WD_TIMEOUT_CYC[WD_W-1:0] - {{(WD_W-1){1'b0}}, 1'b1};

  // Synchronised pins
  wire [14:0] pins_lvl;
  wire sclk_s;
  wire si_s;
  wire cs_n_s;
  wire rst_pin_s;
  wire wake_s;
  wire [3:0] in_s;
  wire wden_s;
  wire vdd_fail_s;
  wire [3:0] fault_s;

  lsw_sync #(
    .WIDTH(15),
    .RST_VAL(`LSW_SYNC_RST)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_sclk, i_serial_in, i_chip_select_n, i_reset_n_pin, i_wake, i_direct_inputs,
              i_watchdog_enable_pin, i_vdd_fail, i_fault_detect}),
    .o_level(pins_lvl)
  );

  assign sclk_s = pins_lvl[14];
  assign si_s = pins_lvl[13];
  assign cs_n_s = pins_lvl[12];
  assign rst_pin_s = pins_lvl[11];
  assign wake_s = pins_lvl[10];
  assign in_s = pins_lvl[9:6];
  assign wden_s = pins_lvl[5];
  assign vdd_fail_s = pins_lvl[4];
  assign fault_s = pins_lvl[3:0];

  // Previous levels for edge detection
  reg sclk_q_ff;
  reg cs_n_q_ff;
  reg rst_q_ff;
  reg wake_q_ff;
  reg [3:0] in_q_ff;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q_ff <= 1'b0;
      cs_n_q_ff <= 1'b1;
      rst_q_ff <= 1'b0;
      wake_q_ff <= 1'b0;
      in_q_ff <= 4'h0;
    end else begin
      sclk_q_ff <= sclk_s;
      cs_n_q_ff <= cs_n_s;
      rst_q_ff <= rst_pin_s;
      wake_q_ff <= wake_s;
      in_q_ff <= in_s;
    end
  end

  // Clock edges count only inside a frame
  wire sclk_rise = sclk_s & ~sclk_q_ff & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_q_ff & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_n_q_ff;
  wire cs_rise = cs_n_s & ~cs_n_q_ff;
  wire wake_lvl = rst_pin_s | wake_s | (|in_s);
  wire wake_edge = (rst_pin_s & ~rst_q_ff) | (wake_s & ~wake_q_ff) | (|(in_s & ~in_q_ff));

  // Configuration and mode state
  reg [3:0] on_ff;
  reg [3:0] dir_dis_ff;
  reg pwm_en_ff;
  reg vdd_fail_en_ff;
  reg [2:0] sense_sel_ff;
  reg sense_hiz_ff;
  reg failsafe_ff;
  reg [WD_W-1:0] wd_cnt_ff;
  reg wd_run_ff;
  reg wd_expired_ff;
  reg wd_last_bit_ff;

  // Shift path
  reg [15:0] rx_ff;
  reg [15:0] tx_ff;
  reg [4:0] bit_cnt_ff;
  wire [15:0] status_word;

  // Whole snapshot built from flops, loaded in a single edge
  assign status_word = {o_mode == MODE_NORMAL, failsafe_ff, wden_s, pwm_en_ff,
                        o_power_outputs, fault_s, in_s};

  // Receive on falling, transmit on rising; first rising keeps the MSB in place
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (cs_fall) begin
      tx_ff <= status_word;
      rx_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (~cs_n_s) begin
      if (sclk_fall) begin
        rx_ff <= {rx_ff[14:0], si_s};
        if (bit_cnt_ff != 5'h1f) begin
          bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
      end
      if (sclk_rise && bit_cnt_ff != 5'h00) begin
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  // Output driver follows chip select; floating from reset until the first frame
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_serial_out_oe_n <= 1'b1;
    end else begin
      o_serial_out_oe_n <= cs_n_s;
    end
  end

  assign o_serial_out = tx_ff[15];

  // Only a complete frame is queued; the serial master cannot be stalled, so a full queue drops
  wire frame_ok = cs_rise & (bit_cnt_ff == `LSW_FRAME_BITS);
  wire fifo_wr_ready;
  wire pop = o_frame_valid & i_frame_ready;
  wire [4:0] frm_addr = o_frame_data[`LSW_ADDR_HI:`LSW_ADDR_LO];
  wire [9:0] frm_data = o_frame_data[`LSW_ADDR_LO-1:0];
  wire frm_wd = o_frame_data[`LSW_WD_BIT];

  lsw_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(frame_ok),
    .i_wr_data(rx_ff),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(o_frame_valid),
    .o_rd_data(o_frame_data),
    .i_rd_ready(i_frame_ready)
  );

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frame_overrun <= 1'b0;
    end else begin
      o_frame_overrun <= frame_ok & ~fifo_wr_ready;
    end
  end

  // Defaults apply under reset pin, in sleep and in fail-safe
  wire cfg_clear = ~rst_pin_s | ~wake_lvl | failsafe_ff;

  // Register commit as each queued frame is drained
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_ff <= 4'h0;
      dir_dis_ff <= 4'h0;
      pwm_en_ff <= 1'b0;
      vdd_fail_en_ff <= 1'b0;
      sense_sel_ff <= 3'h0;
      sense_hiz_ff <= 1'b0;
    end else if (cfg_clear) begin
      on_ff <= 4'h0;
      dir_dis_ff <= 4'h0;
      pwm_en_ff <= 1'b0;
      vdd_fail_en_ff <= 1'b0;
      sense_sel_ff <= 3'h0;
      sense_hiz_ff <= 1'b0;
    end else if (pop) begin
      case (frm_addr)
        `LSW_ADDR_OUT_ON: begin
          on_ff <= frm_data[3:0];
        end
        `LSW_ADDR_DIR_DIS: begin
          dir_dis_ff <= frm_data[3:0];
        end
        `LSW_ADDR_CONFIG: begin
          pwm_en_ff <= frm_data[`LSW_CFG_PWM_EN];
          vdd_fail_en_ff <= frm_data[`LSW_CFG_VDD_FAIL_EN];
          sense_sel_ff <= frm_data[`LSW_CFG_SENSE_HI:`LSW_CFG_SENSE_LO];
          sense_hiz_ff <= frm_data[`LSW_CFG_SENSE_HIZ];
        end
        default: begin
          on_ff <= on_ff;
        end
      endcase
    end
  end

  // Watchdog: started by wake edges, restarted by a toggled top bit
  wire wd_toggle = pop & (frm_wd != wd_last_bit_ff);
  wire fs_exit = pop & frm_wd & ~vdd_fail_s;
  wire wd_kill = ~rst_pin_s | ~wake_lvl | ~wden_s;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wd_cnt_ff <= {WD_W{1'b0}};
      wd_run_ff <= 1'b0;
      wd_expired_ff <= 1'b0;
      wd_last_bit_ff <= 1'b0;
    end else if (wd_kill) begin
      wd_cnt_ff <= {WD_W{1'b0}};
      wd_run_ff <= 1'b0;
      wd_expired_ff <= 1'b0;
      wd_last_bit_ff <= 1'b0;
    end else begin
      if (pop) begin
        wd_last_bit_ff <= frm_wd;
      end
      if (wake_edge | wd_toggle | (failsafe_ff & fs_exit)) begin
        wd_cnt_ff <= {WD_W{1'b0}};
        wd_run_ff <= 1'b1;
        wd_expired_ff <= 1'b0;
      end else if (wd_run_ff) begin
        if (wd_cnt_ff == WD_LAST) begin
          wd_run_ff <= 1'b0;
          wd_expired_ff <= 1'b1;
        end else begin
          wd_cnt_ff <= wd_cnt_ff + {{(WD_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Fail-safe is latched; the expiry that set it must not veto the exit frame
  wire fail_cause = (vdd_fail_s & vdd_fail_en_ff) | (wd_expired_ff & wden_s & ~failsafe_ff);

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      failsafe_ff <= 1'b0;
    end else if (~rst_pin_s | ~wake_lvl) begin
      failsafe_ff <= 1'b0;
    end else if (fail_cause) begin
      failsafe_ff <= 1'b1;
    end else if (fs_exit) begin
      failsafe_ff <= 1'b0;
    end
  end

  // Output selection per mode
  reg [3:0] nxt_power;
  reg [1:0] nxt_mode;

  always @* begin
    nxt_power = 4'h0;
    nxt_mode = MODE_SLEEP;
    if (!wake_lvl) begin
      nxt_mode = MODE_SLEEP;
      nxt_power = 4'h0;
    end else if (failsafe_ff) begin
      nxt_mode = MODE_FAILSAFE;
      nxt_power = in_s;
    end else begin
      nxt_mode = MODE_NORMAL;
      if (pwm_en_ff) begin
        nxt_power = on_ff & i_pwm_duty;
      end else begin
        nxt_power = (in_s & ~dir_dis_ff) | on_ff;
      end
    end
  end

  // Registered pin outputs
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_power_outputs <= 4'h0;
      o_mode <= MODE_SLEEP;
      o_pwm_clk <= 1'b0;
      o_fault_flag_n_out <= 1'b0;
      o_fault_flag_n_oe_n <= 1'b1;
      o_sense_select <= 3'h0;
      o_sense_hiz <= 1'b0;
    end else begin
      o_power_outputs <= nxt_power;
      o_mode <= nxt_mode;
      o_pwm_clk <= pwm_en_ff & in_s[0];
      o_fault_flag_n_out <= 1'b0;
      o_fault_flag_n_oe_n <= ~(|fault_s);
      o_sense_select <= sense_sel_ff;
      o_sense_hiz <= sense_hiz_ff;
    end
  end

endmodule // lsw_top

// ### lsw_defs.vh
// Shared constants for the lamp switch serial and pin control block
`ifndef LSW_DEFS_VH
`define LSW_DEFS_VH

// Timing
`define LSW_CLK_PERIOD_NS 4
`define LSW_WD_TIMEOUT_US 100

// Frame layout
`define LSW_FRAME_BITS 5'h10
`define LSW_WD_BIT 15
`define LSW_ADDR_HI 14
`define LSW_ADDR_LO 10

// Register addresses
`define LSW_ADDR_OUT_ON 5'h01
`define LSW_ADDR_DIR_DIS 5'h02
`define LSW_ADDR_CONFIG 5'h03

// Config register fields
`define LSW_CFG_PWM_EN 0
`define LSW_CFG_VDD_FAIL_EN 1
`define LSW_CFG_SENSE_LO 2
`define LSW_CFG_SENSE_HI 4
`define LSW_CFG_SENSE_HIZ 5

// Reset value of the synchronised pin vector (chip select high, enable pin open)
`define LSW_SYNC_RST 15'h1020

`endif

// ### lsw_sync.v
// Three-stage pin synchroniser with agreement filter
module lsw_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Raw pins and filtered levels
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_level
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;

  // Stage one feeds only stage two; level moves only when stages two and three agree
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      o_level <= (s2_ff & s3_ff) | (o_level & (s2_ff ^ s3_ff)) | (o_level & s2_ff & s3_ff);
    end
  end

endmodule // lsw_sync

// ### lsw_fifo.v
// Flop-based frame FIFO with valid/ready on both sides
module lsw_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Fill side
  input wire i_wr_valid,
  input wire [WIDTH-1:0] i_wr_data,
  output wire o_wr_ready,
  // Drain side
  output wire o_rd_valid,
  output wire [WIDTH-1:0] o_rd_data,
  input wire i_rd_ready
);

  localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW-1:0] PTR_LAST = DEPTH[AW-1:0] - PTR_ONE;
  localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [WIDTH-1:0] head_ff;
  reg valid_ff;
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg [AW:0] nxt_count;
  reg [AW-1:0] nxt_rd_ptr;
  wire push;
  wire pop;

  // Drain side leaves flops so the top's outputs carry no mux glitches
  assign o_wr_ready = (count_ff != DEPTH[AW:0]);
  assign o_rd_valid = valid_ff;
  assign o_rd_data = head_ff;
  assign push = i_wr_valid & o_wr_ready;
  assign pop = valid_ff & i_rd_ready;

  // Next occupancy and read pointer; pointers wrap at DEPTH, which need not be a power of two
  always @* begin
    nxt_count = count_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + CNT_ONE;
    end else if (pop & ~push) begin
      nxt_count = count_ff - CNT_ONE;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? {AW{1'b0}} : rd_ptr_ff + PTR_ONE;
    end
  end

  // Storage and head written without reset; a write into the slot being exposed bypasses the array
  always @(posedge i_core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_wr_data;
    end
    head_ff <= (push && (wr_ptr_ff == nxt_rd_ptr)) ? i_wr_data : mem_ff[nxt_rd_ptr];
  end

  // Pointers, count and valid need a defined start
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? {AW{1'b0}} : wr_ptr_ff + PTR_ONE;
      end
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      valid_ff <= (nxt_count != {(AW+1){1'b0}});
    end
  end

endmodule // lsw_fifo

// ### lsw_top_asserts.sv
// Port checker for the lamp switch serial and pin control block
module lsw_top_chk (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Pins seen from outside
  input wire i_sclk,
  input wire i_chip_select_n,
  input wire i_reset_n_pin,
  input wire i_wake,
  input wire [3:0] i_direct_inputs,
  input wire [3:0] i_fault_detect,
  input wire i_frame_ready,
  // Block outputs
  input wire o_serial_out,
  input wire o_serial_out_oe_n,
  input wire [3:0] o_power_outputs,
  input wire o_pwm_clk,
  input wire o_fault_flag_n_out,
  input wire o_fault_flag_n_oe_n,
  input wire [2:0] o_sense_select,
  input wire o_sense_hiz,
  input wire [1:0] o_mode,
  input wire o_frame_valid,
  input wire [15:0] o_frame_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Windows of 8 cycles on pins cover the pin synchroniser latency; the mode window is 3 cycles
  so_float_a: assert property (i_chip_select_n [*8] |-> o_serial_out_oe_n)
    else $error("serial out driven while deselected");
  so_drive_a: assert property (!i_chip_select_n [*8] |-> !o_serial_out_oe_n)
    else $error("serial out not driven while selected");
  so_hold_a: assert property ($stable({i_sclk, i_chip_select_n}) [*8] |-> $stable(o_serial_out))
    else $error("serial out moved without a clock edge");
  sleep_off_a: assert property ((!i_reset_n_pin && !i_wake && i_direct_inputs == 4'h0) [*8]
    |-> o_mode == 2'h0 && o_power_outputs == 4'h0) else $error("awake with no wake source");
  fs_follow_a: assert property ((o_mode == 2'h2 && $stable(i_direct_inputs)) [*8]
    |-> o_power_outputs == i_direct_inputs) else $error("fail-safe outputs not following inputs");
  flag_low_a: assert property ((i_fault_detect != 4'h0) [*8]
    |-> !o_fault_flag_n_oe_n && !o_fault_flag_n_out) else $error("fault flag not pulled low");
  flag_idle_a: assert property ((i_fault_detect == 4'h0) [*8] |-> o_fault_flag_n_oe_n)
    else $error("fault flag low without fault");
  pwm_clk_a: assert property (!i_direct_inputs[0] [*8] |-> !o_pwm_clk)
    else $error("pwm clock high with input zero low");
  cfg_clear_a: assert property ((o_mode != 2'h1) [*3] |-> o_sense_select == 3'h0 && !o_sense_hiz)
    else $error("sense setting kept outside normal mode");
  frame_hold_a: assert property (o_frame_valid && !i_frame_ready |=> o_frame_valid && $stable(o_frame_data))
    else $error("pending frame lost before drain");
endmodule // lsw_top_chk

// ### lsw_host.sv
// Host controller model driving the serial link of the lamp switch
module lsw_host (
  // Device serial output
  input wire i_so,
  input wire i_so_oe_n,
  // Host driven link
  output logic o_sclk,
  output logic o_si,
  output logic o_cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle link: clock parked low, deselected
  initial begin
    o_sclk = 1'h0;
    o_si = 1'h0;
    o_cs_n = 1'h1;
  end
  // One frame of n bits, MSB first; n below 16 cuts it short
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'hxxxx;
    o_cs_n = 1'h0;
    #200;
    for (int b = 15; b > 15 - n; b--) begin
      o_sclk = 1'h1;
      o_si = tx[b];
      #40;
      rx[b] = i_so_oe_n ? 1'hx : i_so;
      o_sclk = 1'h0;
      #40;
    end
    o_cs_n = 1'h1;
    o_si = ~o_si; // Released line shows no stale bit
    #160;
  endtask
endmodule // lsw_host

// ### lsw_top_tb.sv
// Self-checking bench for the lamp switch serial and pin control block
module lsw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, rst = 1'h1, rpin_n = 1'h0, wake = 1'h0, wdp = 1'h0;
  logic vf = 1'h0, frdy = 1'h1, wdt = 1'h0;
  logic [3:0] din = 4'h0, fd = 4'h0, duty = 4'h0, on;
  logic [9:0] d;
  logic [15:0] rx;
  logic [15:0] fq[$];
  wire sclk, si, cs_n, so, so_oe_n, pclk, ff_n, ff_oe_n, shiz, ovr, fval;
  wire [3:0] pwr;
  wire [2:0] ssel;
  wire [1:0] mode;
  wire [15:0] fdat;
  int fails = 0;
  int tests_run = 0;
  int novr = 0;

  always #2 clk = ~clk;

  lsw_host u_host (.i_so(so), .i_so_oe_n(so_oe_n), .o_sclk(sclk), .o_si(si), .o_cs_n(cs_n));

  lsw_top #(.WD_TIMEOUT_CYC(1000)) dut (.i_core_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_serial_in(si),
    .i_chip_select_n(cs_n), .o_serial_out(so), .o_serial_out_oe_n(so_oe_n), .i_reset_n_pin(rpin_n),
    .i_wake(wake), .i_direct_inputs(din), .i_watchdog_enable_pin(wdp), .i_vdd_fail(vf),
    .i_fault_detect(fd), .i_pwm_duty(duty), .o_power_outputs(pwr), .o_pwm_clk(pclk),
    .o_fault_flag_n_out(ff_n), .o_fault_flag_n_oe_n(ff_oe_n), .o_sense_select(ssel), .o_sense_hiz(shiz),
    .o_mode(mode), .o_frame_overrun(ovr), .o_frame_valid(fval), .o_frame_data(fdat), .i_frame_ready(frdy));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Full frames are noted for the drain side; watchdog bit toggles per full frame
  task automatic send(input int n, input logic [4:0] a, input logic [9:0] dd);
    logic [15:0] w;
    w = {wdt, a, dd};
    if (n == 16) fq.push_back(w);
    u_host.xfer(n, w, rx);
    if (n == 16) wdt = ~wdt;
    idle(1);
  endtask

  task automatic end_of_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Drain side: each popped frame against the oldest note
  always @(posedge clk) begin
    if (!rst && ovr) novr++;
    if (!rst && fval && frdy) chk("frame", fq.size() > 0 ? fq.pop_front() : 16'hxxxx, fdat);
  end

  // Hang guard, well beyond the expected run
  initial begin
    #300000;
    fails++;
    end_of_test;
  end

  initial begin
    void'($urandom(32'he242));
    idle(20);
    rst = 1'h0;
    idle(2);
    chk("oe_n", 16'h1, so_oe_n);
    for (int k = 0; k < 6; k++) begin
      {rpin_n, wake, din} = 6'h1 << k;
      idle(12);
      chk("wake", {2'h1, din}, {mode, pwr});
      {rpin_n, wake, din} = 6'h0;
      idle(12);
      chk("sleep", 16'h0, {mode, pwr});
    end
    {rpin_n, wake} = 2'h3;
    din = 4'($urandom);
    fd = 4'($urandom) | 4'h8;
    d = 10'($urandom) & 10'h03c;
    idle(12);
    chk("flag", 16'h0, {ff_n, ff_oe_n});
    send(16, 5'h03, d);
    chk("status", {2'h2, wdp, 1'h0, din, fd, din}, rx);
    chk("sense", d[5:2], {shiz, ssel});
    send(8, 5'h03, ~d);
    chk("short", d[5:2], {shiz, ssel});
    rpin_n = 1'h0;
    idle(12);
    chk("pin clear", 16'h0, {shiz, ssel});
    rpin_n = 1'h1;
    on = 4'($urandom);
    duty = 4'($urandom);
    send(16, 5'h02, 10'h00f);
    send(16, 5'h01, {6'h0, on});
    chk("on bits", on, pwr);
    send(16, 5'h03, 10'h001);
    chk("pwm out", on & duty, pwr);
    for (int i = 0; i < 4; i++) begin
      din[0] = ~din[0];
      idle(10);
      chk("pwm clk", din[0], pclk);
    end
    send(16, 5'h03, 10'h002);
    vf = 1'h1;
    idle(12);
    chk("vdd fail", {2'h2, din, 4'h0}, {mode, pwr, shiz, ssel});
    vf = 1'h0;
    wdt = 1'h1;
    send(16, 5'h00, 10'h000);
    chk("fs status", {2'h1, wdp, 1'h0, din, fd, din}, rx);
    chk("resume", {2'h1, din}, {mode, pwr});
    {rpin_n, wake, din} = 6'h0;
    wdp = 1'h1;
    idle(12);
    rpin_n = 1'h1;
    idle(500);
    chk("wd run", 16'h1, mode);
    idle(700);
    din = 4'($urandom);
    idle(12);
    chk("wd expiry", {2'h2, din}, {mode, pwr});
    wdp = 1'h0;
    wdt = 1'h1;
    send(16, 5'h00, 10'h000);
    chk("wd exit", 16'h1, mode);
    frdy = 1'h0;
    for (int i = 0; i < 17; i++) send(16, 5'h1f, 10'($urandom));
    void'(fq.pop_back());
    chk("overrun", 16'h1, 16'(novr));
    frdy = 1'h1;
    idle(40);
    chk("drained", 16'h0, {fval, 8'(fq.size())});
    chk("bad addr", 16'h0, {shiz, ssel, pwr ^ din});
    rst = 1'h1;
    idle(3);
    chk("reset", 16'h1, {mode, pwr, so_oe_n});
    rst = 1'h0;
    idle(5);
    end_of_test;
  end
endmodule // lsw_top_tb

bind lsw_top lsw_top_chk u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
  .i_chip_select_n(i_chip_select_n), .i_reset_n_pin(i_reset_n_pin), .i_wake(i_wake),
  .i_direct_inputs(i_direct_inputs), .i_fault_detect(i_fault_detect), .i_frame_ready(i_frame_ready),
  .o_serial_out(o_serial_out), .o_serial_out_oe_n(o_serial_out_oe_n), .o_power_outputs(o_power_outputs),
  .o_pwm_clk(o_pwm_clk), .o_fault_flag_n_out(o_fault_flag_n_out), .o_fault_flag_n_oe_n(o_fault_flag_n_oe_n),
  .o_sense_select(o_sense_select), .o_sense_hiz(o_sense_hiz), .o_mode(o_mode), .o_frame_valid(o_frame_valid),
  .o_frame_data(o_frame_data));
